//--- bench/tb_timing_signal_routing.sv
`timescale 1ns/1ns
module tb_timing_signal_routing;
  logic clock, resetn, psel, penable, pwrite, conv_start, pready, pslverr;
  logic csp, stb_n, sl;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] want, lvl;
  logic [12:0] int_evt, ext_sig, ext_valid;
  logic [2:0] ded;
  tsr_pkg::tsr_pin_drv_t pin;
  int err_total, num_checks, cyc, i, n, m;
  tsr_top DUT (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .programmable_function_pin_i(lvl), .programmable_function_pin(pin),
    .int_evt(int_evt), .conv_start(conv_start), .ext_sig(ext_sig),
    .ext_valid(ext_valid), .dedicated_evt(ded),
    .conversion_sample_pulse(csp), .external_latch_strobe_n(stb_n));
  tsr_ext_model u_ext (.clock(clock), .oe(pin.oe), .o(pin.o),
    .want(want), .lvl(lvl));
  // ==========================================
  // tasks
  task complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pin_evt(input logic v, output int k);
    @(posedge clock);
    want[3] <= v;
    k = 0;
    repeat (8) begin @(negedge clock); k += (ext_sig[0] === 1'b1); end
  endtask
  task burst(input logic [31:0] c, input int half);
    apb(1'b1, tsr_pkg::A_CTRL, c);
    apb(1'b1, tsr_pkg::A_CTRL, c | 32'h20);
    n = 0;
    while (stb_n && n < 99) begin @(negedge clock); n++; end
    for (i = 0; i < 8; i++) begin
      m = 0;
      while (!stb_n && m < 300) begin @(negedge clock); m++; end
      chk(m, half);
      n = 0;
      while (stb_n && n < 300) begin @(negedge clock); n++; end
    end
    chk(n, 300);
  endtask
  // ==========================================
  // clock and watchdog
  initial begin clock = 0; forever #10 clock = ~clock; end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin err_total++; complete_run(); end
  end
  // ==========================================
  // sequence
  initial begin
    {resetn, psel, penable, pwrite, conv_start} = 0;
    {paddr, pwdata, want, int_evt} = 0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    chk(pin.oe, 0);
    chk(stb_n, 1);
    apb(1'b0, tsr_pkg::A_CTRL, 0);
    chk(rd, 32'(tsr_pkg::CTRL_RST));
    apb(1'b0, tsr_pkg::A_SEL1, 0);
    chk(rd, 32'h000fffff);
    apb(1'b0, 8'h40, 0);
    chk(rd, 32'h0);
    chk(sl, 1);
    apb(1'b1, tsr_pkg::A_OE, 32'h3ff);
    apb(1'b0, tsr_pkg::A_OE, 0);
    chk(rd, 32'h3ff);
    @(posedge clock) int_evt <= 13'h401;
    @(posedge clock) int_evt <= 13'h0;
    repeat (3) begin
      @(negedge clock);
      chk({lvl[0], ded[0]}, 2'b11);
    end
    @(negedge clock) chk({lvl[0], ded[0]}, 2'b00);
    apb(1'b1, tsr_pkg::A_OE, 0);
    apb(1'b1, tsr_pkg::A_SEL0, 32'hf4fffff3);
    // valid register follows the stored selector one edge later
    repeat (2) @(negedge clock);
    chk(ext_valid[1:0], 2'b01);
    apb(1'b0, tsr_pkg::A_SEL0, 0);
    chk(rd, 32'hf4fffff3);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, tsr_pkg::A_POL, 32'(p) << 3);
      pin_evt(p[0], n);
      pin_evt(!p[0], n);
      chk(n, 1);
      pin_evt(p[0], n);
      chk(n, 0);
    end
    apb(1'b1, tsr_pkg::A_LVL, 32'h40);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clock) want[4] <= v[0];
      repeat (30) @(negedge clock);
      chk(ext_sig[6], v);
    end
    // pin 3 left high, pin 4 low, no burst running
    apb(1'b0, tsr_pkg::A_STAT, 0);
    chk(rd, 32'h8);
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, tsr_pkg::A_CTRL, (p == 2) ? 32'h8 : 32'h9 | 32'(p) << 1);
      @(posedge clock) conv_start <= 1'b1;
      @(posedge clock) conv_start <= 1'b0;
      n = 0;
      do begin @(negedge clock); n++; end while (csp == p[0] && n < 40);
      m = 0;
      while (csp != p[0] && m < 40) begin @(negedge clock); m++; end
      chk(n, (p == 2) ? 40 : 5);
      chk(m, (p == 2) ? 0 : 20);
      chk(csp, p[0]);
    end
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, tsr_pkg::A_CTRL, 32'(v) << 3);
      repeat (2) @(negedge clock);
      chk(stb_n, v);
    end
    burst(32'h1c, 30);
    burst(32'h0c, 250);
    complete_run();
  end
endmodule

//--- bench/tsr_assertions.sv
`timescale 1ns/1ns
module tsr_chk (
  // clock and reset
  input wire logic                     clock,
  input wire logic                     resetn,
  // apb
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pslverr,
  // timing
  input wire logic [tsr_pkg::NSIG-1:0] int_evt,
  input wire logic [tsr_pkg::NSIG-1:0] ext_sig,
  input wire logic [tsr_pkg::NSIG-1:0] ext_valid,
  input wire logic [tsr_pkg::NDED-1:0] dedicated_evt,
  input tsr_pkg::tsr_pin_drv_t         programmable_function_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire wr     = psel && penable && pwrite;
  wire oe_wr  = wr && paddr == tsr_pkg::A_OE;
  wire sel_wr = wr && paddr == tsr_pkg::A_SEL0;
  property p_evt_on;
    int_evt[0] |=> programmable_function_pin.o[0] [*3];
  endproperty
  a_evt_on: assert property (p_evt_on) else $error("pin short");
  property p_evt_off;
    !int_evt[0] [*3] |=> !programmable_function_pin.o[0];
  endproperty
  a_evt_off: assert property (p_evt_off) else $error("pin long");
  property p_ded;
    int_evt[10] |=> dedicated_evt[0] [*3];
  endproperty
  a_ded: assert property (p_ded) else $error("ded short");
  property p_ext_one;
    ext_sig[0] |=> !ext_sig[0];
  endproperty
  a_ext_one: assert property (p_ext_one) else $error("evt wide");
  property p_valid;
    $changed(ext_valid[7:0]) |-> $past(sel_wr) || $past(sel_wr, 2);
  endproperty
  a_valid: assert property (p_valid) else $error("valid moved");
  property p_oe_wr;
    oe_wr |=> programmable_function_pin.oe == $past(pwdata[9:0]);
  endproperty
  a_oe_wr: assert property (p_oe_wr) else $error("oe bad");
  property p_oe_hold;
    !oe_wr |=> $stable(programmable_function_pin.oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("oe moved");
  property p_slverr;
    psel && !penable && paddr > 8'h18 |=> pslverr && prdata == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("no err");
endmodule

bind tsr_top tsr_chk u_chk (.clock(clock), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .int_evt(int_evt),
  .ext_sig(ext_sig), .ext_valid(ext_valid), .dedicated_evt(dedicated_evt),
  .programmable_function_pin(programmable_function_pin));

//--- bench/tsr_ext_model.sv
`timescale 1ns/1ns
module tsr_ext_model (
  // pin side
  input  wire logic       clock,
  input  wire logic [9:0] oe,
  input  wire logic [9:0] o,
  input  wire logic [9:0] want,
  output logic      [9:0] lvl
);
  logic [9:0] drv_r;
  // level held at least one full cycle
  always_ff @(posedge clock) drv_r <= want;
  // outside drive only where the pin is not driving
  assign lvl = (oe & o) | (~oe & drv_r);
endmodule

//--- rtl/tsr_pkg.sv
package tsr_pkg;

  // ==========================================================
  // sizes
  localparam int NPIN = 10;
  localparam int NSIG = 13;
  localparam int NDED = 3;
  localparam int SELW = 4;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OE   = 8'h04;
  localparam logic [7:0] A_POL  = 8'h08;
  localparam logic [7:0] A_LVL  = 8'h0c;
  localparam logic [7:0] A_SEL0 = 8'h10;
  localparam logic [7:0] A_SEL1 = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;

  // ==========================================================
  // fields and reset values
  localparam int          CTRL_GO_BIT  = 5;
  localparam int          SEL_PER_WORD = 8;
  localparam logic [4:0]  CTRL_RST     = 5'h08;
  localparam logic [9:0]  PIN_RST      = 10'h000;
  localparam logic [12:0] SIG_RST      = 13'h0000;
  localparam logic [3:0]  SEL_NONE     = 4'hf;
  // signals whose consumer accepts level detection
  localparam logic [12:0] LVL_OK       = 13'h0040;

  // ==========================================================
  // timing
  localparam int CLK_NS      = 20;
  localparam int EVT_MIN_NS  = 50;
  localparam int SCAN_DLY_NS = 50;
  localparam int SCAN_W_NS   = 400;
  localparam int STB_SLOW_NS = 10000;
  localparam int STB_FAST_NS = 1200;
  localparam int EVT_CYC     = (EVT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCAN_DLY_CYC = (SCAN_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCAN_W_CYC  = (SCAN_W_NS + CLK_NS - 1) / CLK_NS;
  localparam int STB_SLOW_HALF = STB_SLOW_NS / CLK_NS / 2;
  localparam int STB_FAST_HALF = STB_FAST_NS / CLK_NS / 2;
  localparam int STB_PULSES  = 8;

  // ==========================================================
  // control word
  typedef struct packed {
    logic strobe_fast;
    logic strobe_lvl;
    logic strobe_hw;
    logic scan_pol;
    logic scan_en;
  } tsr_cfg_t;

  // ==========================================================
  // programmable pin pair
  typedef struct packed {
    logic [NPIN-1:0] o;
    logic [NPIN-1:0] oe;
  } tsr_pin_drv_t;

endpackage

//--- rtl/tsr_top.sv
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module tsr_top (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     resetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic      [31:0]              prdata,
  output logic                          pslverr,
  // programmable function pins
  input  wire logic [tsr_pkg::NPIN-1:0] programmable_function_pin_i,
  output tsr_pkg::tsr_pin_drv_t         programmable_function_pin,
  // timing engine side
  input  wire logic [tsr_pkg::NSIG-1:0] int_evt,
  input  wire logic                     conv_start,
  output logic      [tsr_pkg::NSIG-1:0] ext_sig,
  output logic      [tsr_pkg::NSIG-1:0] ext_valid,
  // dedicated outputs
  output logic      [tsr_pkg::NDED-1:0] dedicated_evt,
  output logic                          conversion_sample_pulse,
  output logic                          external_latch_strobe_n
);

  // ==========================================================
  // registers
  tsr_pkg::tsr_cfg_t                  cfg_r;
  logic [tsr_pkg::NPIN-1:0]           oe_r;
  logic [tsr_pkg::NPIN-1:0]           pol_r;
  logic [tsr_pkg::NSIG-1:0]           lvl_r;
  logic [tsr_pkg::SELW-1:0]           sel_r [tsr_pkg::NSIG];
  logic [tsr_pkg::NPIN-1:0]           sync1_r;
  logic [tsr_pkg::NPIN-1:0]           sync2_r;
  logic [tsr_pkg::NSIG-1:0]           prev_r;
  logic [tsr_pkg::NSIG-1:0]           sig_r;
  logic [tsr_pkg::NSIG-1:0]           val_r;
  logic [2:0]                         evt_cnt_r [tsr_pkg::NSIG];
  logic [tsr_pkg::NSIG-1:0]           evt_out;
  logic [2:0]                         sdly_r;
  logic [4:0]                         swid_r;
  logic [8:0]                         half_r;
  logic [4:0]                         phase_r;
  logic                               burst_r;

  // ==========================================================
  // bus decode
  wire       wr_en    = psel & penable & pwrite;
  wire       setup    = psel & ~penable;
  wire       hit_ctrl = (paddr == tsr_pkg::A_CTRL);
  wire       hit_oe   = (paddr == tsr_pkg::A_OE);
  wire       hit_pol  = (paddr == tsr_pkg::A_POL);
  wire       hit_lvl  = (paddr == tsr_pkg::A_LVL);
  wire       hit_sel0 = (paddr == tsr_pkg::A_SEL0);
  wire       hit_sel1 = (paddr == tsr_pkg::A_SEL1);
  wire       hit_stat = (paddr == tsr_pkg::A_STAT);
  wire       mapped   = hit_ctrl | hit_oe | hit_pol | hit_lvl |
                        hit_sel0 | hit_sel1 | hit_stat;
  wire       go_wr    = wr_en & hit_ctrl & pwdata[tsr_pkg::CTRL_GO_BIT];
  wire [8:0] half_len = cfg_r.strobe_fast ?
                        9'(tsr_pkg::STB_FAST_HALF) :
                        9'(tsr_pkg::STB_SLOW_HALF);

  logic [31:0] sel0_word;
  logic [31:0] sel1_word;
  logic [31:0] rd_mux;

  always_comb begin
    sel0_word = 32'h0000_0000;
    sel1_word = 32'h0000_0000;
    for (int k = 0; k < tsr_pkg::SEL_PER_WORD; k++) begin
      sel0_word[k*4 +: 4] = sel_r[k];
    end
    for (int k = tsr_pkg::SEL_PER_WORD; k < tsr_pkg::NSIG; k++) begin
      sel1_word[(k-tsr_pkg::SEL_PER_WORD)*4 +: 4] = sel_r[k];
    end
  end

  assign rd_mux = hit_ctrl ? {27'h0, cfg_r} :
                  hit_oe   ? {22'h0, oe_r} :
                  hit_pol  ? {22'h0, pol_r} :
                  hit_lvl  ? {19'h0, lvl_r} :
                  hit_sel0 ? sel0_word :
                  hit_sel1 ? sel1_word :
                  hit_stat ? {21'h0, burst_r, sync2_r} :
                  32'h0000_0000;

  // zero wait state: read data captured in the setup cycle
  assign pready = 1'b1;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~mapped;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= tsr_pkg::CTRL_RST;
      oe_r  <= tsr_pkg::PIN_RST;
      pol_r <= tsr_pkg::PIN_RST;
      lvl_r <= tsr_pkg::SIG_RST;
    end else if (wr_en) begin
      if (hit_ctrl) cfg_r <= pwdata[4:0];
      if (hit_oe)   oe_r  <= pwdata[9:0];
      if (hit_pol)  pol_r <= pwdata[9:0];
      if (hit_lvl)  lvl_r <= pwdata[12:0];
    end
  end

  // ==========================================================
  // input synchroniser
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= tsr_pkg::PIN_RST;
      sync2_r <= tsr_pkg::PIN_RST;
    end else begin
      sync1_r <= programmable_function_pin_i;
      sync2_r <= sync1_r;
    end
  end

  // ==========================================================
  // per-signal routing and output stretch
  for (genvar s = 0; s < tsr_pkg::NSIG; s++) begin : g_sig
    localparam int WI = (s < tsr_pkg::SEL_PER_WORD) ? 0 : 1;
    localparam int FL = (s % tsr_pkg::SEL_PER_WORD) * 4;
    wire        sel_ok = sel_r[s] < 4'(tsr_pkg::NPIN);
    wire [3:0]  idx    = sel_ok ? sel_r[s] : 4'h0;
    wire        raw    = sync2_r[idx] ^ pol_r[idx];
    wire        act    = sel_ok & raw;
    wire        is_lvl = lvl_r[s] & tsr_pkg::LVL_OK[s];
    wire        sel_wr = wr_en & (WI == 0 ? hit_sel0 : hit_sel1);

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        sel_r[s] <= tsr_pkg::SEL_NONE;
      end else if (sel_wr) begin
        sel_r[s] <= pwdata[FL +: 4];
      end
    end

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        prev_r[s] <= 1'b0;
        sig_r[s]  <= 1'b0;
        val_r[s]  <= 1'b0;
      end else begin
        prev_r[s] <= act;
        // level passes straight through, edge gives one pulse
        sig_r[s]  <= is_lvl ? act : (act & ~prev_r[s]);
        val_r[s]  <= sel_ok;
      end
    end

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        evt_cnt_r[s] <= 3'h0;
      end else if (int_evt[s]) begin
        evt_cnt_r[s] <= 3'(tsr_pkg::EVT_CYC);
      end else if (evt_cnt_r[s] != 3'h0) begin
        evt_cnt_r[s] <= evt_cnt_r[s] - 3'h1;
      end
    end

    assign evt_out[s] = (evt_cnt_r[s] != 3'h0);
  end

  assign ext_sig   = sig_r;
  assign ext_valid = val_r;

  // ==========================================================
  // pin drivers: pin n carries internal signal n
  assign programmable_function_pin.o  =
    evt_out[tsr_pkg::NPIN-1:0];
  assign programmable_function_pin.oe = oe_r;
  // remaining signals leave on dedicated lines
  assign dedicated_evt = evt_out[tsr_pkg::NSIG-1:tsr_pkg::NPIN];

  // ==========================================================
  // conversion sample pulse
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sdly_r <= 3'h0;
      swid_r <= 5'h00;
    end else begin
      if (conv_start && cfg_r.scan_en) begin
        sdly_r <= 3'(tsr_pkg::SCAN_DLY_CYC);
      end else if (sdly_r != 3'h0) begin
        sdly_r <= sdly_r - 3'h1;
      end
      if (!cfg_r.scan_en) begin
        swid_r <= 5'h00;
      end else if (sdly_r == 3'h1) begin
        swid_r <= 5'(tsr_pkg::SCAN_W_CYC);
      end else if (swid_r != 5'h00) begin
        swid_r <= swid_r - 5'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conversion_sample_pulse <= 1'b0;
    end else begin
      conversion_sample_pulse <=
        (swid_r != 5'h00) ^ cfg_r.scan_pol;
    end
  end

  // ==========================================================
  // external latch strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      burst_r <= 1'b0;
      half_r  <= 9'h000;
      phase_r <= 5'h00;
    end else if (!burst_r) begin
      if (go_wr && cfg_r.strobe_hw) begin
        burst_r <= 1'b1;
        half_r  <= half_len;
        phase_r <= 5'h00;
      end
    end else if (half_r != 9'h001) begin
      half_r <= half_r - 9'h001;
    end else if (phase_r == 5'(2*tsr_pkg::STB_PULSES-1)) begin
      burst_r <= 1'b0;
    end else begin
      half_r  <= half_len;
      phase_r <= phase_r + 5'h01;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      external_latch_strobe_n <= 1'b1;
    end else if (burst_r) begin
      external_latch_strobe_n <= phase_r[0];
    end else begin
      external_latch_strobe_n <= cfg_r.strobe_lvl;
    end
  end

endmodule
